//--- pp_core.sv
/*
 * Profile position command and status logic with limit switch handling,
 * reached by software over a classic Wishbone slave.
 * Assumes an external profile generator that consumes cmd_o and reports
 * demand position, standstill and reachability on the same clock.
 */
// Our own choice: the Wishbone slave port.
// Overview of operation
// RQ1 - Passing an active limit switch sets warning bit 7 and runs the reaction
// RQ2 - Reaction -1 none; 1/2 brake then disable; 5/6 brake then quick stop
// RQ3 - While a limit switch is active, travel toward it is refused
// RQ4 - Warning clears only after switch released and axis moved back past it
// RQ5 - Entering quick stop leaves control bit 2 untouched
// RQ6 - Master leaves quick stop by driving bit 2 low then high
// RQ7 - Every absolute target is clamped into the software limits
// RQ8 - Outside the software limits only moves back toward the range pass
// RQ9 - Inputs and objects are sampled once per 1 ms tick
// RQ10 - Master selects profile position by writing mode value 1
// RQ11 - New-setpoint rising edge starts a move; mode entry with it high too
// RQ12 - Immediate bit set runs a new command now, else after current one
// RQ13 - Relative bit chooses absolute or relative target; option picks base
// RQ14 - Halt bit brakes with halt option ramp; clearing resumes on start ramp
// RQ15 - Pass-through bit passes the target instead of stopping there
// RQ16 - Pass-through is ignored when ramp speed cannot be met at target
// RQ17 - Target reached once inside tolerance window for the dwell time
// RQ18 - Limit exceeded while demand position lies outside software limits
// RQ19 - Set-point acknowledge follows the new-setpoint bit
// RQ20 - Buffered command: ack drops when buffer frees; command during ack lost
// RQ21 - No ack for unreachable target or when a target is already buffered
// RQ22 - Following error flagged when over window longer than timeout
// RQ23 - Option bits 4 and 5 let the device clear new-setpoint itself
`timescale 1ns/1ns
`include "pp_defines.svh"
module pp_core import pp_pkg::*; #(
	parameter int unsigned APP_TICK_CYC = 32'(`PP_NS2CYC(`PP_APP_NS)),
	parameter int unsigned VEL_TICK_CYC = 32'(`PP_NS2CYC(`PP_VEL_NS)),
	parameter int unsigned CUR_TICK_CYC = 32'(`PP_NS2CYC(`PP_CUR_NS))
) (
	input wire logic clk_i, // 25 MHz clock
	input wire logic rst_i, // Synchronous reset
	input wire logic ce_i, // Clock enable
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Bus strobe
	input wire logic wb_we_i, // Bus write
	input wire logic [17:0] wb_adr_i, // Byte address
	input wire logic [31:0] wb_dat_i, // Write data
	input wire logic [3:0] wb_sel_i, // Byte enables
	output logic wb_ack_o, // Bus acknowledge
	output logic [31:0] wb_dat_o, // Read data
	input wire logic lim_pos_i, // Positive limit switch pin
	input wire logic lim_neg_i, // Negative limit switch pin
	input wire pp_pos_t act_pos_i, // Actual position
	input wire pp_pos_t dmd_pos_i, // Demand position
	input wire logic reach_ok_i, // Target reachable within limits
	input wire logic ramp_ok_i, // Ramp speed met at target point
	input wire logic move_done_i, // Generator at standstill
	input wire logic closed_loop_i, // Closed loop operation
	input wire logic [31:0] ferr_mag_i, // Following error magnitude
	output pp_cmd_t cmd_o, // Travel command
	output logic cmd_valid_o, // Command pulse
	output logic halt_o, // Halt request
	output logic [1:0] halt_opt_o, // Halt deceleration select
	output logic stop_quick_o, // Braking uses quick stop ramp
	output pp_pstate_t pstate_o, // Power state
	output logic [15:0] status_o, // Status word
	output logic vel_tick_o, // Velocity loop tick
	output logic cur_tick_o // Current loop tick
);
	pp_core_st_t s;
	pp_core_st_t n;
	logic [2:0] ticks;
	logic tick;
	logic req;
	logic wr;
	logic [15:0] idx;
	logic [31:0] rdat;
	logic [31:0] wd;
	logic [15:0] stat;
	logic lim_rise;
	logic mode_act;
	logic edge_nsp;
	logic dir_ok;
	logic accept;
	logic imm;
	pp_pos_t base;
	pp_pos_t raw;
	pp_pos_t clamped;
	pp_pos_t diff;

	function automatic logic [31:0] wmask(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			wmask[8*i +: 8] = be[i] ? d[8*i +: 8] : o[8*i +: 8];
		end
	endfunction

	pp_tick #(
		.APP_CYC(APP_TICK_CYC),
		.VEL_CYC(VEL_TICK_CYC),
		.CUR_CYC(CUR_TICK_CYC)
	) u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.tick_o(ticks)
	);

	assign tick = ticks[0];
	assign vel_tick_o = ticks[1];
	assign cur_tick_o = ticks[2];

	////////////////////////////////////////////////////////////////////
	// Register map
	always_comb begin
		stat = 16'h0;
		stat[`PP_SW_WARN] = s.warn;
		stat[`PP_SW_TREACH] = s.treach;
		stat[`PP_SW_LIMEX] = s.limex;
		stat[`PP_SW_ACK] = s.ack_sp;
		stat[`PP_SW_FERR] = s.ferr;
		idx = wb_adr_i[17:2];
		unique case (idx)
			`PP_IDX_CTRL: rdat = {16'h0, s.ctrl};
			`PP_IDX_STAT: rdat = {16'h0, stat};
			`PP_IDX_MODE: rdat = {24'h0, s.mode};
			`PP_IDX_TGT: rdat = s.tgt;
			`PP_IDX_REACT: rdat = {24'h0, s.react};
			`PP_IDX_SWMIN: rdat = s.swmin;
			`PP_IDX_SWMAX: rdat = s.swmax;
			`PP_IDX_POSOPT: rdat = {16'h0, s.posopt};
			`PP_IDX_TOLWIN: rdat = s.tolwin;
			`PP_IDX_DWELL: rdat = {16'h0, s.dwell};
			`PP_IDX_FEWIN: rdat = s.fewin;
			`PP_IDX_FETMO: rdat = {16'h0, s.fetmo};
			default: rdat = 32'h0;
		endcase
		wd = wmask(rdat, wb_dat_i, wb_sel_i);
	end

	////////////////////////////////////////////////////////////////////
	// Command evaluation, combinational helpers
	assign req = wb_cyc_i & wb_stb_i & ~s.ack;
	assign wr = req & wb_we_i;
	assign lim_rise = (s.lp_s2 & ~s.lp) | (s.ln_s2 & ~s.ln);
	assign mode_act = (s.mode == `PP_MODE_PP); // [RQ10]
	assign imm = s.ctrl[`PP_CW_IMM];
	assign edge_nsp = tick & mode_act & (s.pstate == PP_OP) &
		s.ctrl[`PP_CW_NSP] & (~s.nsp_d | ~s.mode_d); // [RQ11]
	// Reference for relative moves: option 0 is the preceding target
	assign base = (s.posopt[1:0] == 2'b00) ? s.last_tgt : act_pos_i; // [RQ13]
	assign raw = s.ctrl[`PP_CW_REL] ? base + s.tgt : s.tgt; // [RQ13]
	assign clamped = (raw > s.swmax) ? s.swmax :
		(raw < s.swmin) ? s.swmin : raw; // [RQ7]
	assign diff = act_pos_i - s.last_tgt;
	always_comb begin
		dir_ok = 1'b1;
		if (s.lp_s2 && clamped > act_pos_i) dir_ok = 1'b0; // [RQ3]
		if (s.ln_s2 && clamped < act_pos_i) dir_ok = 1'b0; // [RQ3]
		if (act_pos_i > s.swmax && clamped >= act_pos_i) dir_ok = 1'b0; // [RQ8]
		if (act_pos_i < s.swmin && clamped <= act_pos_i) dir_ok = 1'b0; // [RQ8]
	end
	// A full buffer or a pending ack swallows the command
	assign accept = edge_nsp & ~s.ack_sp & reach_ok_i & dir_ok &
		(imm | ~s.moving | ~s.buf_full); // [RQ20] [RQ21]

	////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		n = s;
		n.ack = req;
		n.dat = rdat;
		n.cmd_v = 1'b0;
		n.lp_s1 = lim_pos_i;
		n.lp_s2 = s.lp_s1;
		n.ln_s1 = lim_neg_i;
		n.ln_s2 = s.ln_s1;
		if (tick) begin
			// Everything below sees inputs only at the tick
			n.lp = s.lp_s2; // [RQ9]
			n.ln = s.ln_s2; // [RQ9]
			n.nsp_d = s.ctrl[`PP_CW_NSP];
			n.mode_d = mode_act;
			n.halt = s.ctrl[`PP_CW_HALT]; // [RQ14]
			n.limex = (dmd_pos_i > s.swmax) | (dmd_pos_i < s.swmin); // [RQ18]
			if (lim_rise) begin
				n.warn = 1'b1; // [RQ1]
				n.warn_pside = s.lp_s2;
				n.warn_pos = act_pos_i;
			end else if (s.warn && !s.lp_s2 && !s.ln_s2 &&
				(s.warn_pside ? act_pos_i < s.warn_pos :
				act_pos_i > s.warn_pos)) begin
				n.warn = 1'b0; // [RQ4]
			end
			unique case (s.pstate)
				PP_OP: begin
					if (lim_rise && s.react != `PP_REACT_NONE) begin
						n.pstate = PP_BRAKE; // [RQ1]
						n.stop_quick = (s.react == `PP_REACT_QUICK_DIS) ||
							(s.react == `PP_REACT_QUICK_QS); // [RQ2]
						n.brake_dis = (s.react == `PP_REACT_SLOW_DIS) ||
							(s.react == `PP_REACT_QUICK_DIS); // [RQ2]
						n.moving = 1'b0;
						n.buf_full = 1'b0;
					end
				end
				PP_BRAKE: begin
					// Control word is not touched on the way in
					if (move_done_i) begin
						n.pstate = s.brake_dis ? PP_SOD : PP_QSA; // [RQ2] [RQ5]
						n.qs_low = 1'b0;
					end
				end
				PP_QSA, PP_SOD: begin
					if (!s.ctrl[`PP_CW_QS]) n.qs_low = 1'b1;
					if (s.qs_low && s.ctrl[`PP_CW_QS]) begin
						n.pstate = PP_OP; // [RQ6]
						n.stop_quick = 1'b0;
					end
				end
			endcase
			if (move_done_i && s.moving && s.pstate == PP_OP) begin
				if (s.buf_full) begin
					n.cmd = s.buf_cmd; // [RQ12]
					n.cmd_v = 1'b1;
					n.buf_full = 1'b0;
				end else begin
					n.moving = 1'b0;
				end
			end
			if (accept) begin
				n.ack_sp = 1'b1; // [RQ19]
				n.last_tgt = clamped;
				if (imm || !n.moving) begin
					n.cmd.target = clamped; // [RQ12]
					n.cmd.pass = 1'b0;
					n.cmd_v = 1'b1;
					n.moving = 1'b1;
					n.buf_full = 1'b0;
				end else begin
					n.buf_cmd.target = clamped;
					// Pass-through only when speed holds at the target
					n.buf_cmd.pass = s.ctrl[`PP_CW_PASS] & ramp_ok_i; // [RQ15] [RQ16]
					n.buf_full = 1'b1;
				end
				if (s.posopt[`PP_PO_AUTOCLR_LSB +: 2] != 2'b00) begin
					n.ctrl[`PP_CW_NSP] = 1'b0; // [RQ23]
				end
			end else if (!s.ctrl[`PP_CW_NSP] && !n.buf_full) begin
				n.ack_sp = 1'b0; // [RQ19] [RQ20]
			end
			// A move accepted at this tick drops target reached at once
			if (!n.moving && (diff[31] ? -diff : diff) <= $signed(s.tolwin)) begin
				if (s.dwell_cnt != 16'hffff) n.dwell_cnt = s.dwell_cnt + 16'h1;
				n.treach = (n.dwell_cnt >= s.dwell); // [RQ17]
			end else begin
				n.dwell_cnt = 16'h0;
				n.treach = 1'b0;
			end
			if (closed_loop_i && ferr_mag_i > s.fewin) begin
				if (s.fe_cnt != 16'hffff) n.fe_cnt = s.fe_cnt + 16'h1;
				n.ferr = (n.fe_cnt > s.fetmo); // [RQ22]
			end else begin
				n.fe_cnt = 16'h0;
				n.ferr = 1'b0;
			end
		end
		// Bus write last, so a software write beats the auto-clear
		if (wr) begin
			unique case (idx)
				`PP_IDX_CTRL: n.ctrl = wd[15:0];
				`PP_IDX_MODE: n.mode = wd[7:0];
				`PP_IDX_TGT: n.tgt = wd;
				`PP_IDX_REACT: n.react = wd[7:0];
				`PP_IDX_SWMIN: n.swmin = wd;
				`PP_IDX_SWMAX: n.swmax = wd;
				`PP_IDX_POSOPT: n.posopt = wd[15:0];
				`PP_IDX_TOLWIN: n.tolwin = wd;
				`PP_IDX_DWELL: n.dwell = wd[15:0];
				`PP_IDX_FEWIN: n.fewin = wd;
				`PP_IDX_FETMO: n.fetmo = wd[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.react <= `PP_REACT_NONE;
			s.swmin <= `PP_RST_SWMIN;
			s.swmax <= `PP_RST_SWMAX;
			s.pstate <= PP_OP;
		end else if (ce_i) begin
			s <= n;
		end
	end

	assign wb_ack_o = s.ack;
	assign wb_dat_o = s.dat;
	assign cmd_o = s.cmd;
	assign cmd_valid_o = s.cmd_v;
	assign halt_o = s.halt;
	assign halt_opt_o = s.posopt[`PP_PO_HALT_LSB +: 2];
	assign stop_quick_o = s.stop_quick;
	assign pstate_o = s.pstate;
	assign status_o = {2'b00, s.ferr, s.ack_sp, s.limex, s.treach, 2'b00,
		s.warn, 7'h00};

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_bus_req;
		ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_brake_done;
		ce_i && tick && s.pstate == PP_BRAKE && move_done_i && !wr;
	endsequence

	AST_WB_ACK: assert property (s_bus_req |=> wb_ack_o)
		else $error("bus request not acknowledged");
	AST_WARN_SET: assert property (ce_i && tick && lim_rise |=> s.warn) // [RQ1]
		else $error("limit switch did not set warning");
	AST_REACT_QS: assert property (ce_i && tick && lim_rise && // [RQ2]
		s.pstate == PP_OP && s.react == `PP_REACT_QUICK_QS
		|=> s.pstate == PP_BRAKE && s.stop_quick && !s.brake_dis)
		else $error("quick stop reaction not taken");
	AST_DIR_BLOCK: assert property (accept && s.lp_s2 |-> // [RQ3]
		clamped <= act_pos_i)
		else $error("move toward active limit accepted");
	AST_WARN_HOLD: assert property (s.warn && (s.lp_s2 || s.ln_s2) // [RQ4]
		|=> s.warn)
		else $error("warning cleared while switch active");
	AST_QS_KEEP: assert property (s_brake_done |=> // [RQ5]
		s.ctrl[`PP_CW_QS] == $past(s.ctrl[`PP_CW_QS]))
		else $error("quick stop bit changed on entry");
	AST_CLAMP: assert property (accept |-> // [RQ7]
		clamped <= s.swmax && clamped >= s.swmin)
		else $error("target outside software limits");
	AST_NO_REPEAT: assert property (ce_i && tick && s.nsp_d && // [RQ11]
		s.mode_d && mode_act |-> !accept)
		else $error("command without new edge");
	AST_IMMEDIATE: assert property (ce_i && accept && imm |=> // [RQ12]
		cmd_valid_o && cmd_o.target == $past(clamped))
		else $error("immediate command not issued");
	AST_TREACH: assert property (s.treach |-> // [RQ17]
		s.dwell_cnt >= s.dwell && !s.moving)
		else $error("target reached before dwell");
	AST_LIMEX: assert property (ce_i && tick && dmd_pos_i > s.swmax // [RQ18]
		|=> s.limex)
		else $error("limit exceeded not flagged");
	AST_ACK_FALL: assert property (ce_i && tick && !accept && // [RQ19]
		!s.ctrl[`PP_CW_NSP] && !n.buf_full |=> !s.ack_sp)
		else $error("acknowledge did not follow new set point");
	AST_DISCARD: assert property (s.ack_sp |-> !accept) // [RQ20]
		else $error("command taken while acknowledge high");
	AST_FERR: assert property ($rose(s.ferr) |-> // [RQ22]
		s.fe_cnt > s.fetmo && $past(closed_loop_i))
		else $error("following error flagged early");
endmodule // pp_core

//--- pp_defines.svh
/*
 * Register indices, field positions, reset values and timing counts of
 * the profile position command block.
 * Assumes a 25 MHz clock; byte address of a register is four times its index.
 */
`ifndef PP_DEFINES_SVH
`define PP_DEFINES_SVH

// Register indices
`define PP_IDX_CTRL 16'h6040
`define PP_IDX_STAT 16'h6041
`define PP_IDX_MODE 16'h6060
`define PP_IDX_TGT 16'h607a
`define PP_IDX_REACT 16'h7000
`define PP_IDX_SWMIN 16'h7001
`define PP_IDX_SWMAX 16'h7002
`define PP_IDX_POSOPT 16'h7003
`define PP_IDX_TOLWIN 16'h7004
`define PP_IDX_DWELL 16'h7005
`define PP_IDX_FEWIN 16'h7006
`define PP_IDX_FETMO 16'h7007

// Control word bits
`define PP_CW_QS 2
`define PP_CW_NSP 4
`define PP_CW_IMM 5
`define PP_CW_REL 6
`define PP_CW_HALT 8
`define PP_CW_PASS 9

// Status word bits
`define PP_SW_WARN 7
`define PP_SW_TREACH 10
`define PP_SW_LIMEX 11
`define PP_SW_ACK 12
`define PP_SW_FERR 13

// Positioning option fields
`define PP_PO_AUTOCLR_LSB 4
`define PP_PO_HALT_LSB 8

// Mode and limit reaction codes
`define PP_MODE_PP 8'h01
`define PP_REACT_NONE 8'hff
`define PP_REACT_SLOW_DIS 8'h01
`define PP_REACT_QUICK_DIS 8'h02
`define PP_REACT_SLOW_QS 8'h05
`define PP_REACT_QUICK_QS 8'h06

// Reset values
`define PP_RST_SWMIN 32'h80000000
`define PP_RST_SWMAX 32'h7fffffff

// Timing
`define PP_CLK_HZ 64'd25000000
`define PP_APP_NS 64'd1000000
`define PP_VEL_NS 64'd250000
`define PP_CUR_NS 64'd62500
`define PP_NS2CYC(ns) (((ns) * `PP_CLK_HZ) / 64'd1000000000)

`endif

//--- pp_gen_model.sv
/*
 * Motion generator model facing the profile position command block.
 * Assumes the command port runs on the same clock; moves take a few
 * cycles, or about fifty application ticks when slow_i is high.
 */
`timescale 1ns/1ns
module pp_gen_model import pp_pkg::*; (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Synchronous reset
	input wire pp_cmd_t cmd_i, // Travel command
	input wire logic cmd_valid_i, // Command pulse
	input wire logic halt_i, // Halt request
	input wire logic slow_i, // Long moves
	output pp_pos_t act_pos_o, // Actual position
	output pp_pos_t dmd_pos_o, // Demand position
	output logic move_done_o // Standstill
);
	logic [9:0] left_ff;
	// Position jumps at move end; no ramp arithmetic is modelled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			act_pos_o <= '0;
			dmd_pos_o <= '0;
			move_done_o <= 1'b1;
			left_ff <= '0;
		end else if (cmd_valid_i) begin
			dmd_pos_o <= cmd_i.target;
			move_done_o <= 1'b0;
			left_ff <= slow_i ? 10'd1000 : 10'd3;
		end else if (!move_done_o && !halt_i) begin
			if (left_ff == 10'd0) begin
				act_pos_o <= dmd_pos_o;
				move_done_o <= 1'b1;
			end else begin
				left_ff <= left_ff - 10'd1;
			end
		end
	end
endmodule // pp_gen_model

//--- pp_pkg.sv
/*
 * Types shared by the profile position command block.
 * Assumes positions are 32-bit two's complement user units.
 */
package pp_pkg;

	typedef logic signed [31:0] pp_pos_t;

	typedef enum logic [3:0] {
		PP_OP = 4'b0001,
		PP_BRAKE = 4'b0010,
		PP_QSA = 4'b0100,
		PP_SOD = 4'b1000
	} pp_pstate_t;

	typedef struct packed {
		pp_pos_t target;
		logic pass;
	} pp_cmd_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic [15:0] ctrl;
		logic [7:0] mode;
		pp_pos_t tgt;
		logic [7:0] react;
		pp_pos_t swmin;
		pp_pos_t swmax;
		logic [15:0] posopt;
		logic [31:0] tolwin;
		logic [15:0] dwell;
		logic [31:0] fewin;
		logic [15:0] fetmo;
		logic lp_s1;
		logic lp_s2;
		logic ln_s1;
		logic ln_s2;
		logic lp;
		logic ln;
		logic nsp_d;
		logic mode_d;
		pp_pstate_t pstate;
		logic qs_low;
		logic brake_dis;
		logic stop_quick;
		logic warn;
		logic warn_pside;
		pp_pos_t warn_pos;
		logic ack_sp;
		logic treach;
		logic limex;
		logic ferr;
		logic moving;
		logic buf_full;
		pp_cmd_t buf_cmd;
		pp_cmd_t cmd;
		logic cmd_v;
		logic halt;
		pp_pos_t last_tgt;
		logic [15:0] dwell_cnt;
		logic [15:0] fe_cnt;
	} pp_core_st_t;

endpackage

//--- pp_tick.sv
/*
 * Free running tick generators for the application, velocity and current
 * loop periods; each output is a one-cycle pulse from a flip-flop.
 * Assumes one clock; all counters freeze while ce_i is low.
 */
`timescale 1ns/1ns
module pp_tick #(
	parameter int unsigned APP_CYC = 25000,
	parameter int unsigned VEL_CYC = 6250,
	parameter int unsigned CUR_CYC = 1562
) (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Synchronous reset
	input wire logic ce_i, // Clock enable
	output logic [2:0] tick_o // 0 app, 1 velocity, 2 current
);
	localparam int unsigned PER [3] = '{APP_CYC, VEL_CYC, CUR_CYC};

	for (genvar g = 0; g < 3; g++) begin : g_ch
		logic [31:0] cnt_ff;
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				cnt_ff <= 32'h0;
				tick_o[g] <= 1'b0;
			end else if (ce_i) begin
				tick_o[g] <= (cnt_ff == 32'(PER[g] - 1));
				cnt_ff <= (cnt_ff == 32'(PER[g] - 1)) ? 32'h0 : cnt_ff + 32'h1;
			end
		end
	end
endmodule // pp_tick

//--- tb_top.sv
/*
 * Self-checking bench of the profile position command block.
 * Assumes short tick parameters (20 cycles per application tick).
 */
`timescale 1ns/1ns
`include "pp_defines.svh"
module tb_top import pp_pkg::*; ;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [17:0] adr = '0;
	logic [31:0] wdat = '0;
	logic [3:0] sel = '0;
	logic lim_pos = 1'b0, lim_neg = 1'b0, reach_ok = 1'b1, ramp_ok = 1'b1;
	logic closed_loop = 1'b0, slow = 1'b0;
	logic [31:0] ferr_mag = '0;
	logic ack, cmd_v, halt, sq, vt, ct, done;
	logic [31:0] rdat;
	logic [1:0] hopt;
	logic [15:0] stat;
	pp_pos_t act, dmd;
	pp_cmd_t cmd, last_cmd;
	pp_pstate_t pst;
	int n_fail = 0, samples_checked = 0, n_cmd = 0;
	logic [31:0] q;
	pp_core #(.APP_TICK_CYC(20), .VEL_TICK_CYC(8), .CUR_TICK_CYC(4)) i_pp_core (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_sel_i(sel), .wb_ack_o(ack), .wb_dat_o(rdat),
		.lim_pos_i(lim_pos), .lim_neg_i(lim_neg), .act_pos_i(act),
		.dmd_pos_i(dmd), .reach_ok_i(reach_ok), .ramp_ok_i(ramp_ok),
		.move_done_i(done), .closed_loop_i(closed_loop),
		.ferr_mag_i(ferr_mag), .cmd_o(cmd), .cmd_valid_o(cmd_v),
		.halt_o(halt), .halt_opt_o(hopt), .stop_quick_o(sq),
		.pstate_o(pst), .status_o(stat), .vel_tick_o(vt), .cur_tick_o(ct));
	pp_gen_model i_pp_gen_model (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd),
		.cmd_valid_i(cmd_v), .halt_i(halt), .slow_i(slow), .act_pos_o(act),
		.dmd_pos_o(dmd), .move_done_o(done));
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (cmd_v === 1'b1) begin
			n_cmd++;
			last_cmd = cmd;
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Classic cycle: request held until ack is sampled high
	task automatic wb(input logic w, input logic [15:0] i,
		input logic [31:0] d, output logic [31:0] r);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		wdat <= d;
		sel <= 4'hf;
		@(posedge clk_i);
		// Only the watchdog ends a wait for the answer
		while (ack !== 1'b1)
			@(posedge clk_i);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_i);
		chk("ack drop", 32'(ack), 32'h0);
	endtask
	task automatic wr(input logic [15:0] i, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, i, d, r);
	endtask
	task automatic ticks(input int n);
		repeat (n * 20) @(posedge clk_i);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		int nv = 0;
		int nc = 0;
		wb(1'b0, `PP_IDX_REACT, 0, q);
		chk("react", q, 32'hff);
		wb(1'b0, `PP_IDX_SWMIN, 0, q);
		chk("swmin", q, 32'h80000000);
		wb(1'b0, `PP_IDX_SWMAX, 0, q);
		chk("swmax", q, 32'h7fffffff);
		wr(`PP_IDX_STAT, 32'hffff);
		wb(1'b0, `PP_IDX_STAT, 0, q);
		chk("stat ro", q, 32'h0);
		wb(1'b0, 16'h1234, 0, q);
		chk("unmapped", q, 32'h0);
		chk("pstate", 32'(pst), 32'(PP_OP));
		repeat (40) begin
			@(posedge clk_i);
			nv += int'(vt);
			nc += int'(ct);
		end
		chk("vel ticks", 32'(nv), 32'h5);
		chk("cur ticks", 32'(nc), 32'ha);
		$display("test reset done");
	endtask
	task automatic t_moves();
		int tg[3] = '{5000, -300, -5000};
		int ex[3] = '{1000, 700, -1000};
		logic [31:0] rl[3] = '{32'h0, 32'h40, 32'h0};
		wr(`PP_IDX_TGT, 32'd500);
		wr(`PP_IDX_CTRL, 32'h34);
		ticks(2);
		chk("no cmd mode 0", 32'(n_cmd), 32'h0);
		wr(`PP_IDX_MODE, 32'h1);
		ticks(2);
		chk("entry cmd", 32'(n_cmd), 32'h1);
		chk("entry tgt", last_cmd.target, 32'd500);
		for (int i = 0; i < 3; i++) begin
			chk("ack high", 32'(stat[12]), 32'h1);
			wr(`PP_IDX_CTRL, 32'h24);
			ticks(2);
			chk("ack low", 32'(stat[12]), 32'h0);
			wr(`PP_IDX_TGT, tg[i]);
			wr(`PP_IDX_CTRL, 32'h34 | rl[i]);
			ticks(2);
			chk("cmd count", 32'(n_cmd), 32'(i + 2));
			chk("target", last_cmd.target, ex[i]);
		end
		ticks(6);
		chk("reached", 32'(stat[10]), 32'h1);
		wr(`PP_IDX_CTRL, 32'h24);
		reach_ok <= 1'b0;
		ticks(2);
		wr(`PP_IDX_CTRL, 32'h34);
		ticks(2);
		chk("unreach ack", 32'(stat[12]), 32'h0);
		chk("unreach cmd", 32'(n_cmd), 32'h4);
		reach_ok <= 1'b1;
		wr(`PP_IDX_CTRL, 32'h24);
		ticks(2);
		$display("test moves done");
	endtask
	task automatic t_buffer();
		slow <= 1'b1;
		wr(`PP_IDX_TGT, 32'd100);
		wr(`PP_IDX_CTRL, 32'h14);
		ticks(2);
		chk("first", last_cmd.target, 32'd100);
		wr(`PP_IDX_CTRL, 32'h04);
		ticks(2);
		chk("ack free", 32'(stat[12]), 32'h0);
		wr(`PP_IDX_TGT, 32'd200);
		wr(`PP_IDX_CTRL, 32'h214);
		ticks(2);
		chk("buffered ack", 32'(stat[12]), 32'h1);
		chk("held back", 32'(n_cmd), 32'h5);
		wr(`PP_IDX_CTRL, 32'h204);
		ticks(2);
		chk("full ack", 32'(stat[12]), 32'h1);
		wr(`PP_IDX_TGT, 32'd300);
		wr(`PP_IDX_CTRL, 32'h214);
		ticks(55);
		chk("issued", 32'(n_cmd), 32'h6);
		chk("buf tgt", last_cmd.target, 32'd200);
		chk("pass", 32'(last_cmd.pass), 32'h1);
		wr(`PP_IDX_CTRL, 32'h204);
		ticks(55);
		chk("dropped", 32'(n_cmd), 32'h6);
		slow <= 1'b0;
		$display("test buffer done");
	endtask
	task automatic t_halt_lim();
		wr(`PP_IDX_POSOPT, 32'h200);
		wr(`PP_IDX_CTRL, 32'h104);
		ticks(2);
		chk("halt", 32'(halt), 32'h1);
		chk("halt opt", 32'(hopt), 32'h2);
		wr(`PP_IDX_CTRL, 32'h04);
		ticks(2);
		chk("resume", 32'(halt), 32'h0);
		lim_pos <= 1'b1;
		ticks(2);
		chk("warn", 32'(stat[7]), 32'h1);
		chk("no reaction", 32'(pst), 32'(PP_OP));
		wr(`PP_IDX_TGT, 32'd900);
		wr(`PP_IDX_CTRL, 32'h34);
		ticks(2);
		chk("toward switch", 32'(n_cmd), 32'h6);
		wr(`PP_IDX_CTRL, 32'h24);
		// A tick must see the new set point bit low
		ticks(1);
		wr(`PP_IDX_TGT, -32'sd500);
		wr(`PP_IDX_CTRL, 32'h34);
		ticks(2);
		chk("away", 32'(n_cmd), 32'h7);
		chk("warn held", 32'(stat[7]), 32'h1);
		lim_pos <= 1'b0;
		wr(`PP_IDX_CTRL, 32'h24);
		ticks(3);
		chk("warn clear", 32'(stat[7]), 32'h0);
		$display("test halt and limit done");
	endtask
	task automatic t_react();
		logic [7:0] code[4] = '{8'h01, 8'h02, 8'h05, 8'h06};
		pp_pstate_t ps[4] = '{PP_SOD, PP_SOD, PP_QSA, PP_QSA};
		for (int i = 0; i < 4; i++) begin
			wr(`PP_IDX_REACT, 32'(code[i]));
			lim_neg <= 1'b1;
			ticks(3);
			chk("reaction", 32'(pst), 32'(ps[i]));
			chk("quick ramp", 32'(sq),
				32'(code[i] == 8'h02 || code[i] == 8'h06));
			wb(1'b0, `PP_IDX_CTRL, 0, q);
			chk("qs bit kept", 32'(q[2]), 32'h1);
			lim_neg <= 1'b0;
			wr(`PP_IDX_CTRL, 32'h20);
			ticks(2);
			wr(`PP_IDX_CTRL, 32'h24);
			ticks(2);
			chk("back to op", 32'(pst), 32'(PP_OP));
		end
		wr(`PP_IDX_REACT, 32'hff);
		wr(`PP_IDX_SWMIN, -32'sd400);
		ticks(2);
		chk("lim exceeded", 32'(stat[11]), 32'h1);
		wr(`PP_IDX_SWMIN, -32'sd1000);
		ticks(2);
		chk("lim inside", 32'(stat[11]), 32'h0);
		ferr_mag <= 32'd11;
		ticks(5);
		chk("ferr open", 32'(stat[13]), 32'h0);
		closed_loop <= 1'b1;
		ticks(2);
		chk("ferr early", 32'(stat[13]), 32'h0);
		ticks(3);
		chk("ferr set", 32'(stat[13]), 32'h1);
		wr(`PP_IDX_POSOPT, 32'h210);
		wr(`PP_IDX_TGT, 32'h0);
		wr(`PP_IDX_CTRL, 32'h34);
		ticks(2);
		wb(1'b0, `PP_IDX_CTRL, 0, q);
		chk("auto clear", 32'(q[4]), 32'h0);
		chk("auto cmd", 32'(n_cmd), 32'h8);
		$display("test reaction done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		wr(`PP_IDX_SWMIN, -32'sd1000);
		wr(`PP_IDX_SWMAX, 32'd1000);
		wr(`PP_IDX_DWELL, 32'd1);
		wr(`PP_IDX_FEWIN, 32'd10);
		wr(`PP_IDX_FETMO, 32'd2);
		t_moves();
		t_buffer();
		t_halt_lim();
		t_react();
		complete_run();
	end
	// Tests need about 5000 cycles; four times that is a hang
	initial begin
		#(40 * 20000);
		n_fail++;
		complete_run();
	end
endmodule // tb_top
